// ---- rtl/tone_codec_map.vh ----
`ifndef TONE_CODEC_MAP_VH
`define TONE_CODEC_MAP_VH
// Clock and symbol timing
`define CLK_MHZ 250
`define LONG_US 500
`define SHORT_US 250
`define LONG_CYC (`LONG_US * `CLK_MHZ)
`define SHORT_CYC (`SHORT_US * `CLK_MHZ)
// Acceptance windows as fractions of the nominal half-cycle: 4/5 to 6/5
// gives 200..300 us for short and 400..600 us for long, with a gap between
`define WIN_NUM_LO 4
`define WIN_NUM_HI 6
`define WIN_DEN 5
// Packet layout in half-cycles
`define SYNC_HC 14
`define DATA_HC 48
`define GROUPS 24
`define NULL_GRP 4'hF
// Sync field, one bit per half-cycle, 1 = long, oldest first in bit 13
`define SYNC_PAT 14'h2A95
// Valid data groups, 1 = long, first half-cycle in bit 3
`define PAT_00 4'h3
`define PAT_01 4'h6
`define PAT_10 4'h9
`define PAT_11 4'hC
`endif

// ---- rtl/half_cycle_rx.v ----
`timescale 1ns/1ps
`include "tone_codec_map.vh"
module half_cycle_rx #(
    parameter CNT_W = 18,
    parameter LONG_HC = `LONG_CYC,
    parameter SHORT_HC = `SHORT_CYC
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Synchronised tone input
    input wire tone_in,
    // Classified half-cycle
    output reg hc_valid_out,
    output reg hc_long_out,
    output reg hc_bad_out
);
    reg tone_d;
    reg [CNT_W-1:0] width;
    wire edge_seen;

    // Windows in cycles; the gap between them catches mid-length noise
    localparam integer SHORT_MIN = SHORT_HC * `WIN_NUM_LO / `WIN_DEN;
    localparam integer SHORT_MAX = SHORT_HC * `WIN_NUM_HI / `WIN_DEN;
    localparam integer LONG_MIN = LONG_HC * `WIN_NUM_LO / `WIN_DEN;
    localparam integer LONG_MAX = LONG_HC * `WIN_NUM_HI / `WIN_DEN;

    assign edge_seen = tone_in ^ tone_d;

    ////////////////////////////////////////////////////////////////////
    // Measure each half-cycle and classify it on its closing edge
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tone_d <= 1'b0;
            width <= {CNT_W{1'b0}};
            hc_valid_out <= 1'b0;
            hc_long_out <= 1'b0;
            hc_bad_out <= 1'b0;
        end else begin
            tone_d <= tone_in;
            hc_valid_out <= edge_seen;
            if (edge_seen) begin
                width <= {CNT_W{1'b0}};
                hc_long_out <= (width >= LONG_MIN);
                // Anything outside both windows is flagged bad
                hc_bad_out <= !((width >= SHORT_MIN &&
                    width <= SHORT_MAX) || (width >= LONG_MIN &&
                    width <= LONG_MAX));
            end else if (width != {CNT_W{1'b1}}) begin
                width <= width + 1'b1; // Saturates on a dead line
            end
        end
    end
endmodule // half_cycle_rx

// ---- rtl/half_cycle_tone_codec.v ----
// Overview of operation
// - Encode data into symbols, never pass raw
// - Unbroken tone while transmitting
// - Half-cycles are 500 or 250 us
// - Idle preamble is all long half-cycles
// - Four-half-cycle groups, four valid patterns
// - Invalid group discards the whole packet
// - All-long group is null, packet kept
// - Packet starts with 14 half-cycle sync
// - 48 data half-cycles carry 24 bits
// - Three-byte packet about 23 ms on air
// - Classify each half-cycle before group decode
// - Packet carries sync and three FIFO bytes
// - Missing bytes filled with idle pattern
// - Key transmitter off when FIFO empty
`timescale 1ns/1ps
`include "tone_codec_map.vh"
module half_cycle_tone_codec #(
    parameter CNT_W = 18,
    parameter LONG_HC = `LONG_CYC,
    parameter SHORT_HC = `SHORT_CYC,
    parameter [15:0] GROUP_MAP = {`PAT_11, `PAT_10, `PAT_01, `PAT_00}
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Transmit byte source (FIFO side)
    input wire tx_valid_in,
    input wire [7:0] tx_data_in,
    output wire tx_ready_out,
    // Radio baseband, transmit
    output reg tone_out,
    output reg key_out,
    // Radio baseband, receive
    input wire tone_in,
    // Received bytes (FIFO side)
    output reg rx_valid_out,
    output reg [7:0] rx_data_out
);
    localparam S_IDLE = 4'b0001;
    localparam S_PRE = 4'b0010;
    localparam S_SYNC = 4'b0100;
    localparam S_DATA = 4'b1000;
    // Counter reloads and sync layout; cut to width where they are used
    localparam integer LONG_LOAD = LONG_HC - 1;
    localparam integer SHORT_LOAD = SHORT_HC - 1;
    localparam integer SYNC_N = `SYNC_HC;
    localparam integer SYNC_TOP = `SYNC_HC - 1;
    localparam [13:0] SYNC_WORD = `SYNC_PAT;

    // Group pattern for a dibit, from the one shared map
    function [3:0] pat_of;
        input [1:0] d;
        begin
            pat_of = GROUP_MAP[d*4 +: 4];
        end
    endfunction

    // Dibit for a pattern; bit 2 flags a void group
    function [2:0] dibit_of;
        input [3:0] p;
        begin
            if (p == GROUP_MAP[3:0]) dibit_of = 3'h0;
            else if (p == GROUP_MAP[7:4]) dibit_of = 3'h1;
            else if (p == GROUP_MAP[11:8]) dibit_of = 3'h2;
            else if (p == GROUP_MAP[15:12]) dibit_of = 3'h3;
            else dibit_of = 3'h4;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Transmit side
    reg [3:0] state;
    reg [CNT_W-1:0] hc_cnt;
    reg [5:0] hc_idx;
    reg [23:0] payload;
    reg [2:0] fill;
    reg [1:0] byte_cnt;
    reg sym_long;
    wire hc_end;
    wire [5:0] d_idx;
    wire [3:0] cur_pat;

    assign hc_end = (hc_cnt == {CNT_W{1'b0}});
    assign d_idx = hc_idx - SYNC_N[5:0];
    assign cur_pat = fill[2 - d_idx[5:4]] ?
        pat_of(payload[23 - {d_idx[5:2], 1'b0} -: 2]) : `NULL_GRP;
    // Bytes are taken only while a packet is being assembled
    // A byte taken on the edge that realigns the payload would be lost
    assign tx_ready_out = (state != S_DATA) && (byte_cnt != 2'd3) &&
        !(state == S_SYNC && hc_end && hc_idx == SYNC_TOP);

    // Long or short for the half-cycle after this one
    always @* begin
        if (state == S_SYNC)
            sym_long = SYNC_WORD[SYNC_TOP - hc_idx];
        else if (state == S_DATA)
            sym_long = cur_pat[2'd3 - d_idx[1:0]];
        else
            sym_long = 1'b1;
    end

    // Tone generator: each half-cycle end flips the line
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= S_IDLE;
            hc_cnt <= {CNT_W{1'b0}};
            hc_idx <= 6'd0;
            payload <= 24'h000000;
            fill <= 3'b000;
            byte_cnt <= 2'd0;
            tone_out <= 1'b0;
            key_out <= 1'b0;
        end else begin
            if (tx_valid_in && tx_ready_out) begin
                payload <= {payload[15:0], tx_data_in};
                fill <= {fill[1:0], 1'b1};
                byte_cnt <= byte_cnt + 2'd1;
            end
            if (state == S_IDLE) begin
                if (tx_valid_in) begin
                    state <= S_PRE;
                    key_out <= 1'b1;
                    hc_cnt <= LONG_LOAD[CNT_W-1:0];
                end
            end else if (hc_end) begin
                tone_out <= ~tone_out;
                hc_cnt <= sym_long ? LONG_LOAD[CNT_W-1:0] :
                    SHORT_LOAD[CNT_W-1:0];
                case (state)
                    S_PRE: begin
                        // Keep preamble until a byte is held
                        if (byte_cnt != 2'd0) begin
                            state <= S_SYNC;
                            hc_idx <= 6'd0;
                        end else if (!tx_valid_in) begin
                            state <= S_IDLE;
                            key_out <= 1'b0;
                        end
                    end
                    S_SYNC: begin
                        hc_idx <= hc_idx + 6'd1;
                        if (hc_idx == `SYNC_HC - 1) begin
                            state <= S_DATA;
                            // Left-align short packets; rest is idle
                            if (byte_cnt == 2'd1) begin
                                payload <= {payload[7:0], 16'h0000};
                                fill <= 3'b100;
                            end else if (byte_cnt == 2'd2) begin
                                payload <= {payload[15:0], 8'h00};
                                fill <= 3'b110;
                            end
                        end
                    end
                    S_DATA: begin
                        hc_idx <= hc_idx + 6'd1;
                        if (hc_idx == `SYNC_HC + `DATA_HC - 1) begin
                            state <= S_PRE;
                            byte_cnt <= 2'd0;
                            fill <= 3'b000;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end else begin
                hc_cnt <= hc_cnt - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Receive side: synchroniser, then half-cycle classifier
    reg tone_s1;
    reg tone_s2;
    wire hc_valid;
    wire hc_long;
    wire hc_bad;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tone_s1 <= 1'b0;
            tone_s2 <= 1'b0;
        end else begin
            tone_s1 <= tone_in;
            tone_s2 <= tone_s1;
        end
    end

    half_cycle_rx #(
        .CNT_W(CNT_W),
        .LONG_HC(LONG_HC),
        .SHORT_HC(SHORT_HC)
    ) u_hc (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .tone_in(tone_s2),
        .hc_valid_out(hc_valid),
        .hc_long_out(hc_long),
        .hc_bad_out(hc_bad)
    );

    // Sync hunt over a sliding window, then group decode
    reg [13:0] hist;
    reg in_pkt;
    reg void_pkt;
    reg [5:0] rx_idx;
    reg [2:0] grp;
    reg [23:0] rx_word;
    reg [2:0] rx_fill;
    reg [1:0] out_cnt;
    wire [3:0] grp_now;
    wire [2:0] dib;

    assign grp_now = {grp, hc_long};
    assign dib = dibit_of(grp_now);

    // Packet bytes leave after decode, one per clock; the word is
    // held until all are out, so a following packet is never merged
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hist <= 14'h0000;
            in_pkt <= 1'b0;
            void_pkt <= 1'b0;
            rx_idx <= 6'd0;
            grp <= 3'b000;
            rx_word <= 24'h000000;
            rx_fill <= 3'b000;
            out_cnt <= 2'd0;
            rx_valid_out <= 1'b0;
            rx_data_out <= 8'h00;
        end else begin
            rx_valid_out <= 1'b0;
            if (out_cnt != 2'd0) begin
                out_cnt <= out_cnt - 2'd1;
                if (rx_fill[2]) begin
                    rx_valid_out <= 1'b1;
                    rx_data_out <= rx_word[23:16];
                end
                rx_word <= {rx_word[15:0], 8'h00};
                rx_fill <= {rx_fill[1:0], 1'b0};
            end else if (hc_valid) begin
                hist <= {hist[12:0], hc_long};
                if (!in_pkt) begin
                    if ({hist[12:0], hc_long} == `SYNC_PAT && !hc_bad) begin
                        in_pkt <= 1'b1;
                        void_pkt <= 1'b0;
                        rx_idx <= 6'd0;
                        rx_fill <= 3'b111;
                    end
                end else begin
                    if (hc_bad)
                        void_pkt <= 1'b1;
                    rx_idx <= rx_idx + 6'd1;
                    if (rx_idx[1:0] != 2'd3) begin
                        grp <= {grp[1:0], hc_long};
                    end else if (grp_now == `NULL_GRP) begin
                        // Null group keeps the packet alive
                        rx_word <= {rx_word[21:0], 2'b00};
                        rx_fill[2 - rx_idx[5:4]] <= 1'b0;
                    end else begin
                        rx_word <= {rx_word[21:0], dib[1:0]};
                        if (dib[2])
                            void_pkt <= 1'b1;
                    end
                    if (rx_idx == `DATA_HC - 1) begin
                        in_pkt <= 1'b0;
                        hist <= 14'h0000;
                        // Noisy packets produce no output at all
                        if (!void_pkt && !hc_bad && !(dib[2] &&
                            grp_now != `NULL_GRP))
                            out_cnt <= 2'd3;
                    end
                end
            end
        end
    end
endmodule // half_cycle_tone_codec

// ---- verif/tone_codec_chk.sv ----
`timescale 1ns/1ps
`include "tone_codec_map.vh"
module tone_codec_chk #(
    parameter CNT_W = 18,
    parameter LONG_HC = `LONG_CYC,
    parameter SHORT_HC = `SHORT_CYC
) (
    // Clock and reset
    input wire clk_in,
    input wire rst_b_in,
    // Byte source
    input wire tx_valid_in,
    input wire [7:0] tx_data_in,
    input wire tx_ready_out,
    // Radio side
    input wire tone_out,
    input wire key_out,
    input wire tone_in,
    // Byte sink
    input wire rx_valid_out,
    input wire [7:0] rx_data_out
);
    reg tone_d, in_d, armed;
    reg [19:0] cnt, in_cnt;
    wire flip = tone_out != tone_d;
    // Half-cycle timers; armed only once edges frame a whole half-cycle,
    // so the idle gap before keying is never judged as a width
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tone_d <= 1'b0;
            in_d <= 1'b0;
            armed <= 1'b0;
            cnt <= 20'h0;
            in_cnt <= 20'h0;
        end else begin
            tone_d <= tone_out;
            in_d <= tone_in;
            armed <= key_out && (armed || flip);
            cnt <= flip ? 20'h1 : cnt + 20'h1;
            in_cnt <= (tone_in != in_d) ? 20'h0 : in_cnt + 20'h1;
        end
    end
    ////////////////
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_hc_width;
        armed && flip |-> cnt == LONG_HC || cnt == SHORT_HC;
    endproperty
    a_hc_width: assert property (p_hc_width)
        else $error("bad half-cycle");
    property p_unbroken;
        armed |-> cnt <= LONG_HC;
    endproperty
    a_unbroken: assert property (p_unbroken)
        else $error("tone stalled");
    property p_idle_still;
        !key_out && !$past(key_out, 2) |-> $stable(tone_out);
    endproperty
    a_idle_still: assert property (p_idle_still)
        else $error("tone unkeyed");
    property p_key_start;
        tx_valid_in && tx_ready_out && !key_out |=> key_out;
    endproperty
    a_key_start: assert property (p_key_start)
        else $error("no key");
    property p_key_min;
        $rose(key_out) |-> key_out [*8];
    endproperty
    a_key_min: assert property (p_key_min)
        else $error("short key");
    property p_key_off;
        $fell(key_out) |-> !$past(tx_valid_in);
    endproperty
    a_key_off: assert property (p_key_off)
        else $error("key off early");
    property p_rx_burst;
        rx_valid_out [*3] |=> !rx_valid_out;
    endproperty
    a_rx_burst: assert property (p_rx_burst)
        else $error("long burst");
    property p_rx_edge;
        $rose(rx_valid_out) |-> in_cnt < 20'h40;
    endproperty
    a_rx_edge: assert property (p_rx_edge)
        else $error("late output");
    // Main scenarios reached
    c_burst: cover property (rx_valid_out [*3]);
    c_key_off: cover property ($fell(key_out));
    c_short: cover property (armed && flip && cnt == SHORT_HC);
endmodule // tone_codec_chk
bind half_cycle_tone_codec tone_codec_chk #(.CNT_W(CNT_W),
    .LONG_HC(LONG_HC), .SHORT_HC(SHORT_HC)) chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out),
    .tone_out(tone_out), .key_out(key_out), .tone_in(tone_in),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out));

// ---- verif/radio_path_model.sv ----
`timescale 1ns/1ps
module radio_path_model (
    // Modem transmit side
    input wire tx_tone_in,
    input wire key_in,
    // Bench fault control
    input wire corrupt_in,
    // Receiver baseband
    output wire rx_tone_out
);
    // Keyed tone loops back; a squelched receiver output rests low, and
    // the bench may invert the path to fake a noise burst
    assign rx_tone_out = key_in ? (tx_tone_in ^ corrupt_in) : 1'b0;
endmodule // radio_path_model

// ---- verif/tb_half_cycle_tone_codec.sv ----
`timescale 1ns/1ps
`include "tone_codec_map.vh"
module tb_half_cycle_tone_codec;
    // Half-cycles scaled down so three packets fit a short run
    localparam int LONG_HC = 160;
    localparam int SHORT_HC = 80;
    localparam int LIMIT = 20000;
    logic clk_in = 1'b0, rst_b_in = 1'b0, tx_valid_in = 1'b0, corrupt = 1'b0;
    logic [7:0] tx_data_in = 8'h00;
    wire tx_ready_out, tone_out, key_out, tone_in, rx_valid_out;
    wire [7:0] rx_data_out;
    int fails = 0, comparisons = 0, width = 0, bad_w = 0;
    logic [61:0] hist, expv;
    logic seen = 1'b0, found = 1'b0, tone_d = 1'b0;
    logic [7:0] rxq[$];
    half_cycle_tone_codec #(.LONG_HC(LONG_HC), .SHORT_HC(SHORT_HC)) uut (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
        .tx_ready_out(tx_ready_out), .tone_out(tone_out), .key_out(key_out),
        .tone_in(tone_in), .rx_valid_out(rx_valid_out),
        .rx_data_out(rx_data_out));
    radio_path_model radio (.tx_tone_in(tone_out), .key_in(key_out),
        .corrupt_in(corrupt), .rx_tone_out(tone_in));
    // 250 MHz clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    ////////////////
    // Monitor: keyed half-cycles as L=1/S=0, odd widths counted as bad
    always @(negedge clk_in) begin
        if (rx_valid_out === 1'b1) rxq.push_back(rx_data_out);
        width++;
        // The last flip comes with the key drop, so flips are judged first
        if (tone_out !== tone_d) begin
            if (seen && width == LONG_HC) hist = {hist[60:0], 1'b1};
            else if (seen && width == SHORT_HC) hist = {hist[60:0], 1'b0};
            else if (seen) bad_w++;
            if (hist === expv) found = 1'b1;
            seen = key_out === 1'b1;
            width = 0;
        end else if (key_out !== 1'b1) begin
            seen = 1'b0;
        end
        tone_d = tone_out;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic [15:0] enc(input [7:0] b);
        enc = 16'h0;
        for (int i = 3; i >= 0; i--) enc = {enc[11:0], b[2*i+1] ?
            (b[2*i] ? `PAT_11 : `PAT_10) : (b[2*i] ? `PAT_01 : `PAT_00)};
    endfunction
    // Hold the byte until the edge that samples ready high
    task send(input logic [7:0] b);
        int n;
        logic ok;
        tx_valid_in <= 1'b1;
        tx_data_in <= b;
        n = 0;
        do begin
            @(negedge clk_in);
            ok = tx_ready_out === 1'b1;
            @(posedge clk_in);
            n++;
        end while (!ok && n < LIMIT);
    endtask
    // One packet of n bytes, optionally hit by a 100 us inversion burst
    task pkt(input int n, input logic [23:0] d, input logic bad);
        int k;
        hist = 62'h0;
        found = 1'b0;
        bad_w = 0;
        rxq.delete();
        expv = {`SYNC_PAT, enc(d[23:16]), n > 1 ? enc(d[15:8]) : 16'hFFFF,
            n > 2 ? enc(d[7:0]) : 16'hFFFF};
        for (int i = 0; i < n; i++) send(d[23-8*i -: 8]);
        tx_valid_in <= 1'b0;
        if (bad) begin
            // Lands in the data field; a 100 us burst is a fifth of long
            repeat (LONG_HC * 30) @(posedge clk_in);
            corrupt <= 1'b1;
            repeat (LONG_HC / 5) @(posedge clk_in);
            corrupt <= 1'b0;
        end
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (key_out !== 1'b0 && k < LIMIT);
        // Decoded bytes leave a few cycles after the closing edge
        repeat (16) @(negedge clk_in);
        check(k < LIMIT, 1);
        check(bad_w, 0);
        check(found, 1);
        check(rxq.size(), bad ? 0 : n);
        foreach (rxq[i]) check(rxq[i], d[23-8*i -: 8]);
        @(posedge clk_in);
    endtask
    task t_full; pkt(3, 24'hE41B5A, 1'b0); endtask
    task t_partial; pkt(1, 24'h2D0000, 1'b0); endtask
    task t_noise; pkt(3, 24'hC3963C, 1'b1); endtask
    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge clk_in);
        check({key_out, tone_out, tx_ready_out}, 3'h1);
        rst_b_in <= 1'b1;
        @(posedge clk_in);
        t_full;
        t_partial;
        t_noise;
        stop_test;
    end
    // Watchdog: three scaled packets of about 7900 to 9200 cycles each, with margin
    initial begin
        #240000;
        fails++;
        stop_test;
    end
endmodule // tb_half_cycle_tone_codec
